/* File: rtl/ctv_regs.svh */
// Register map, field positions and reset values of the trigger validation block
// Operation
// - One programmable coincidence unit per channel
// - Channel unit sees requests, GP0-7, soft, external
// - Global and output units exclude GP lines
// - Single board trigger output, OR only
// - One global unit triggers all channels together
// - Validation from channel unit, global unit or sync trigger input
// - Coincidence stores only if validated inside window
// - Coincidence timing from request, never pile-up
// - Paired channels share one combined request
// - Anti-coincidence stores only without validation in window
// - Majority: at least level enabled inputs true; level 0 never hits
// - Neighbour request validates self and both neighbours
// - Neighbour timing measured from validation
// - Neighbour time stamp is validation time
// - Neighbour late validation sets pile-up flag
// - Neighbour validation without own request sets energy bit 15
// - Neighbour validation starts counters without own request
// - Master forwards clock, receivers apply phase shift
// - Boards start, stop and time-stamp together
// - Trigger propagates to all; any busy inhibits all
// - Normal mode holds validation permanently high
// - Separate validation returned to every channel
`ifndef CTV_REGS_SVH
`define CTV_REGS_SVH
`define CTV_CTRL_OFS      8'h00
`define CTV_WIN_OFS       8'h04
`define CTV_GEN_OFS       8'h08
`define CTV_GFN_OFS       8'h0C
`define CTV_TEN_OFS       8'h10
`define CTV_SOFT_OFS      8'h14
`define CTV_PHASE_OFS     8'h18
`define CTV_STAT_OFS      8'h1C
`define CTV_TIME_OFS      8'h20
`define CTV_SCNT_OFS      8'h24
`define CTV_RCNT_OFS      8'h28
`define CTV_CH_BASE       8'h40
`define CTV_CH_STRIDE     8'h08
`define CTV_CH_FN_OFS     8'h04
`define CTV_CTRL_RUN      0
`define CTV_CTRL_MASTER   1
`define CTV_CTRL_MODE_LO  2
`define CTV_CTRL_MODE_HI  3
`define CTV_CTRL_PAIRED   4
`define CTV_FN_LO         0
`define CTV_FN_HI         1
`define CTV_LVL_LO        8
`define CTV_LVL_HI        12
`define CTV_WIN_RST       16'h0010
`define CTV_PHASE_RST     8'h00
`define CTV_LVL_RST       5'h01
`endif

/* File: rtl/ctv_pkg.sv */
// Types shared by the trigger validation block
package ctv_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_COINC, MODE_ANTI, MODE_NEIGH} ctv_mode_t;
  typedef enum logic [1:0] {FUNC_AND, FUNC_OR, FUNC_MAJ} ctv_func_t;
  typedef enum logic [1:0] {WIN_IDLE, WIN_OPEN, WIN_LATE} ctv_win_st_t;
endpackage

/* File: rtl/ctv_win_if.sv */
// Signals between the top level and one channel acceptance window
`timescale 1ns/1ps
`default_nettype none
interface ctv_win_if import ctv_pkg::*; ();
  ctv_mode_t   mode;
  logic [15:0] len;
  logic        req;
  logic        val;
  logic        inhibit;
  logic        start;
  logic        store;
  logic        reject;
  logic        pileup;
  logic        nbr;
  modport win (input mode, len, req, val, inhibit,
               output start, store, reject, pileup, nbr);
  modport top (output mode, len, req, val, inhibit,
               input start, store, reject, pileup, nbr);
endinterface
`default_nettype wire

/* File: rtl/ctv_logic_unit.sv */
// AND, OR or majority over the enabled inputs of one trigger logic unit
`timescale 1ns/1ps
`default_nettype none
module ctv_logic_unit import ctv_pkg::*; #(
  parameter int W = 18
) (
  input  wire logic [W-1:0] in_vec,
  input  wire logic [W-1:0] en_vec,
  input  wire ctv_func_t    func,
  input  wire logic [4:0]   level,
  output logic              hit
);
  initial begin
    if (W < 2 || W > 31) $error("ctv_logic_unit: width out of range");
  end

  logic [4:0] cnt;

  always_comb begin
    cnt = 5'h00;
    for (int k = 0; k < W; k++) begin
      cnt = cnt + 5'(in_vec[k] & en_vec[k]);
    end
  end

  always_comb begin
    unique case (func)
      FUNC_AND: hit = (|en_vec) && ((in_vec | ~en_vec) == {W{1'b1}});
      FUNC_OR:  hit = |(in_vec & en_vec);
      FUNC_MAJ: hit = (level != 5'h00) && (cnt >= level);
      default:  hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/ctv_accept_window.sv */
// Per-channel acceptance window and store decision
`timescale 1ns/1ps
`default_nettype none
module ctv_accept_window import ctv_pkg::*; (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  ctv_win_if.win    wi
);
  ctv_win_st_t st_q;
  logic [15:0] cnt_q;
  logic        seen_q;
  logic        val_prev_q;
  logic        val_rise;

  assign val_rise = wi.val & ~val_prev_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) val_prev_q <= 1'b0;
    else         val_prev_q <= wi.val;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q      <= WIN_IDLE;
      cnt_q     <= 16'h0000;
      seen_q    <= 1'b0;
      wi.start  <= 1'b0;
      wi.store  <= 1'b0;
      wi.reject <= 1'b0;
      wi.pileup <= 1'b0;
      wi.nbr    <= 1'b0;
    end else begin
      wi.start  <= 1'b0;
      wi.store  <= 1'b0;
      wi.reject <= 1'b0;
      if (wi.mode != MODE_NEIGH) wi.pileup <= 1'b0;
      unique case (st_q)
        WIN_IDLE: begin
          if (wi.mode == MODE_NEIGH) begin
            if (wi.req && !wi.inhibit) begin
              st_q   <= WIN_OPEN;
              cnt_q  <= wi.len;
              seen_q <= 1'b0;
            end else if (val_rise && !wi.inhibit) begin
              wi.start  <= 1'b1;
              wi.store  <= 1'b1;
              wi.nbr    <= 1'b1;
              wi.pileup <= 1'b0;
            end
          end else if (wi.req && !wi.inhibit) begin
            wi.start <= 1'b1;
            wi.nbr   <= 1'b0;
            wi.pileup <= 1'b0;
            if (wi.mode == MODE_NORMAL) begin
              wi.store <= 1'b1;
            end else begin
              st_q   <= WIN_OPEN;
              cnt_q  <= wi.len;
              seen_q <= wi.val;
            end
          end
        end
        WIN_OPEN: begin
          cnt_q <= cnt_q - 16'h0001;
          if (wi.mode == MODE_NEIGH) begin
            if (val_rise) begin
              wi.start  <= 1'b1;
              wi.store  <= !wi.inhibit;
              wi.reject <= wi.inhibit;
              wi.pileup <= 1'b0;
              wi.nbr    <= 1'b0;
              st_q      <= WIN_IDLE;
            end else if (cnt_q == 16'h0000) begin
              st_q <= WIN_LATE;
            end
          end else begin
            seen_q <= seen_q | wi.val;
            if (cnt_q == 16'h0000) begin
              st_q <= WIN_IDLE;
              if (wi.mode == MODE_ANTI) begin
                wi.store  <= !(seen_q | wi.val) && !wi.inhibit;
                wi.reject <= (seen_q | wi.val) || wi.inhibit;
              end else begin
                wi.store  <= (seen_q | wi.val) && !wi.inhibit;
                wi.reject <= !(seen_q | wi.val) || wi.inhibit;
              end
            end
          end
        end
        WIN_LATE: begin
          if (val_rise) begin
            wi.start  <= 1'b1;
            wi.store  <= !wi.inhibit;
            wi.reject <= wi.inhibit;
            wi.pileup <= wi.mode == MODE_NEIGH;
            wi.nbr    <= 1'b0;
            st_q      <= WIN_IDLE;
          end else if (wi.req && !wi.inhibit) begin
            st_q  <= WIN_OPEN;
            cnt_q <= wi.len;
          end else if (wi.mode != MODE_NEIGH) begin
            st_q <= WIN_IDLE;
          end
        end
      endcase
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_coinc_needs_val: assert property (
    wi.store && wi.mode == MODE_COINC |-> $past(seen_q) || $past(wi.val))
    else $error("coincidence store without validation in window");
  a_anti_no_val: assert property (
    wi.store && wi.mode == MODE_ANTI |-> !$past(seen_q) && !$past(wi.val))
    else $error("anti-coincidence store despite validation");
  a_coinc_no_pile: assert property (
    wi.mode != MODE_NEIGH && $past(wi.mode) != MODE_NEIGH |-> !wi.pileup)
    else $error("pile-up flag outside neighbour mode");
  a_win_end_only: assert property (
    (wi.store || wi.reject) && wi.mode inside {MODE_COINC, MODE_ANTI}
      && $past(wi.mode) == wi.mode
      |-> $past(st_q) == WIN_OPEN && $past(cnt_q) == 16'h0000)
    else $error("coincidence decision before window end");
  a_nbr_start: assert property (
    wi.mode == MODE_NEIGH && st_q == WIN_IDLE && val_rise && !wi.req && !wi.inhibit
      |=> wi.start && wi.store && wi.nbr)
    else $error("neighbour validation did not start an event");
endmodule
`default_nettype wire

/* File: rtl/ctv_top.sv */
// Board trigger validation: coincidence units, global and output triggers, APB registers
`timescale 1ns/1ps
`default_nettype none
`include "ctv_regs.svh"
module ctv_top import ctv_pkg::*; #(
  parameter int NCH = 8
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NCH-1:0]        chan_trig_request,
  input  wire logic [NCH-1:0]        chan_busy,
  input  wire logic [7:0]            gp_line,
  input  wire logic                  external_trigger_input,
  input  wire logic                  sync_run_in,
  input  wire logic                  sync_busy_in,
  input  wire logic                  sync_trig_in,
  output logic      [NCH-1:0]        trigger_validation,
  output logic      [NCH-1:0]        chan_event_start,
  output logic      [NCH-1:0]        chan_event_store,
  output logic      [NCH-1:0]        chan_event_reject,
  output logic      [NCH-1:0]        chan_pileup_flag,
  output logic      [NCH-1:0]        chan_energy_bit15,
  output logic      [NCH-1:0][31:0]  chan_event_time,
  output logic                       board_trigger_output,
  output logic                       sync_run_out,
  output logic                       sync_busy_out,
  output logic                       sync_trig_out,
  output logic                       clk_master_sel,
  output logic      [7:0]            clk_phase_shift
);
  localparam int CW = NCH + 10;
  localparam int GW = NCH + 2;

  initial begin
    if (NCH < 2 || NCH > 16 || (NCH % 2) != 0) $error("ctv_top: NCH must be even, 2 to 16");
  end

  // Pin inputs pass two flip-flops
  logic [11:0] pin_meta_q;
  logic [11:0] pin_sync_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_meta_q <= 12'h000;
      pin_sync_q <= 12'h000;
    end else begin
      pin_meta_q <= {sync_trig_in, sync_busy_in, sync_run_in, external_trigger_input, gp_line};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic [7:0] gp_s;
  logic       ext_s;
  logic       run_in_s;
  logic       busy_in_s;
  logic       trig_in_s;
  assign gp_s      = pin_sync_q[7:0];
  assign ext_s     = pin_sync_q[8];
  assign run_in_s  = pin_sync_q[9];
  assign busy_in_s = pin_sync_q[10];
  assign trig_in_s = pin_sync_q[11];

  // Control registers
  logic                 run_q;
  logic                 master_q;
  ctv_mode_t            mode_q;
  logic                 paired_q;
  logic [15:0]          win_len_q;
  logic [GW-1:0]        glb_en_q;
  ctv_func_t            glb_fn_q;
  logic [4:0]           glb_lvl_q;
  logic [GW-1:0]        tout_en_q;
  logic                 soft_q;
  logic [7:0]           phase_q;
  logic [31:0]          time_q;
  logic [15:0]          store_cnt_q;
  logic [15:0]          reject_cnt_q;
  logic [NCH-1:0][CW-1:0] ch_en_q;
  ctv_func_t            ch_fn_q  [NCH];
  logic [4:0]           ch_lvl_q [NCH];

  logic wr_acc;
  logic setup;
  assign wr_acc = psel & penable & pwrite;
  assign setup  = psel & ~penable;
  assign pready = 1'b1;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_q     <= 1'b0;
      master_q  <= 1'b0;
      mode_q    <= MODE_NORMAL;
      paired_q  <= 1'b0;
      win_len_q <= `CTV_WIN_RST;
      glb_en_q  <= '0;
      glb_fn_q  <= FUNC_OR;
      glb_lvl_q <= `CTV_LVL_RST;
      tout_en_q <= '0;
      phase_q   <= `CTV_PHASE_RST;
    end else if (wr_acc) begin
      unique case (paddr)
        `CTV_CTRL_OFS: begin
          run_q    <= pwdata[`CTV_CTRL_RUN];
          master_q <= pwdata[`CTV_CTRL_MASTER];
          mode_q   <= ctv_mode_t'(pwdata[`CTV_CTRL_MODE_HI:`CTV_CTRL_MODE_LO]);
          paired_q <= pwdata[`CTV_CTRL_PAIRED];
        end
        `CTV_WIN_OFS: win_len_q <= pwdata[15:0];
        `CTV_GEN_OFS: glb_en_q <= pwdata[GW-1:0];
        `CTV_GFN_OFS: begin
          glb_fn_q  <= ctv_func_t'(pwdata[`CTV_FN_HI:`CTV_FN_LO]);
          glb_lvl_q <= pwdata[`CTV_LVL_HI:`CTV_LVL_LO];
        end
        `CTV_TEN_OFS: tout_en_q <= pwdata[GW-1:0];
        `CTV_PHASE_OFS: phase_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Software trigger is a one-cycle pulse per write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) soft_q <= 1'b0;
    else         soft_q <= wr_acc && paddr == `CTV_SOFT_OFS;
  end

  // Run and busy shared across boards
  logic run_eff;
  logic busy_any;
  logic inhibit;
  assign run_eff  = master_q ? run_q : run_in_s;
  assign busy_any = (|chan_busy) | busy_in_s;
  assign inhibit  = ~run_eff | busy_any;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_run_out    <= 1'b0;
      sync_busy_out   <= 1'b0;
      clk_master_sel  <= 1'b0;
      clk_phase_shift <= `CTV_PHASE_RST;
    end else begin
      sync_run_out    <= master_q & run_q;
      sync_busy_out   <= |chan_busy;
      clk_master_sel  <= master_q;
      clk_phase_shift <= master_q ? `CTV_PHASE_RST : phase_q;
    end
  end

  // Shared time base, cleared while stopped so all boards align on start
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !run_eff) time_q <= 32'h0000_0000;
    else                     time_q <= time_q + 32'h0000_0001;
  end

  // Paired channels merge into one request per pair
  logic [NCH-1:0] req_src;
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      req_src[k] = paired_q ? (chan_trig_request[k] | chan_trig_request[k ^ 1])
                            : chan_trig_request[k];
    end
  end

  // Global and output units see requests, external and software triggers only
  logic [GW-1:0] brd_in;
  logic          global_coincidence_output;
  logic          tout_hit;
  assign brd_in = {ext_s, soft_q, req_src};

  ctv_logic_unit #(.W(GW)) u_glb (
    .in_vec (brd_in),
    .en_vec (glb_en_q),
    .func   (glb_fn_q),
    .level  (glb_lvl_q),
    .hit    (global_coincidence_output)
  );

  ctv_logic_unit #(.W(GW)) u_tout (
    .in_vec (brd_in),
    .en_vec (tout_en_q),
    .func   (FUNC_OR),
    .level  (5'h01),
    .hit    (tout_hit)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      board_trigger_output <= 1'b0;
      sync_trig_out        <= 1'b0;
    end else begin
      board_trigger_output <= tout_hit;
      sync_trig_out        <= tout_hit;
    end
  end

  logic [CW-1:0]  ch_in;
  logic [NCH-1:0] individual_coincidence_output;
  logic [NCH-1:0] stores;
  logic [NCH-1:0] rejects;
  assign ch_in = {ext_s, soft_q, gp_s, req_src};

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic    val_d;
      logic    val_q;
      logic    nbr_req;
      logic    sel;
      ctv_win_if wif ();

      assign sel = wr_acc && (paddr & ~`CTV_CH_FN_OFS) == (`CTV_CH_BASE + 8'(i) * `CTV_CH_STRIDE);

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          ch_en_q[i]  <= '0;
          ch_fn_q[i]  <= FUNC_OR;
          ch_lvl_q[i] <= `CTV_LVL_RST;
        end else if (sel && (paddr & `CTV_CH_FN_OFS) == 8'h00) begin
          ch_en_q[i] <= pwdata[CW-1:0];
        end else if (sel) begin
          ch_fn_q[i]  <= ctv_func_t'(pwdata[`CTV_FN_HI:`CTV_FN_LO]);
          ch_lvl_q[i] <= pwdata[`CTV_LVL_HI:`CTV_LVL_LO];
        end
      end

      ctv_logic_unit #(.W(CW)) u_itl (
        .in_vec (ch_in),
        .en_vec (ch_en_q[i]),
        .func   (ch_fn_q[i]),
        .level  (ch_lvl_q[i]),
        .hit    (individual_coincidence_output[i])
      );

      assign nbr_req = req_src[i] | ((i > 0) ? req_src[(i > 0) ? i - 1 : 0] : 1'b0)
                     | ((i < NCH - 1) ? req_src[(i < NCH - 1) ? i + 1 : i] : 1'b0);

      always_comb begin
        unique case (mode_q)
          MODE_NORMAL: val_d = 1'b1;
          MODE_NEIGH:  val_d = nbr_req;
          default:     val_d = individual_coincidence_output[i] | global_coincidence_output | trig_in_s;
        endcase
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) val_q <= 1'b0;
        else         val_q <= val_d;
      end

      assign wif.mode    = mode_q;
      assign wif.len     = win_len_q;
      assign wif.req     = req_src[i];
      assign wif.val     = val_q;
      assign wif.inhibit = inhibit;

      ctv_accept_window u_win (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .wi      (wif)
      );

      assign trigger_validation[i] = val_q;
      assign chan_event_start[i]   = wif.start;
      assign chan_event_store[i]   = wif.store;
      assign chan_event_reject[i]  = wif.reject;
      assign chan_pileup_flag[i]   = wif.pileup;
      assign chan_energy_bit15[i]  = wif.nbr;
      assign stores[i]             = wif.store;
      assign rejects[i]            = wif.reject;

      // Time stamp taken at the timing reference: validation in neighbour mode
      always_ff @(posedge sys_clk) begin
        if (sys_rst)                 chan_event_time[i] <= 32'h0000_0000;
        else if (wif.start) chan_event_time[i] <= time_q;
      end
    end
  endgenerate

  function automatic logic [15:0] ones(input logic [NCH-1:0] v);
    logic [15:0] n;
    n = 16'h0000;
    for (int k = 0; k < NCH; k++) n = n + 16'(v[k]);
    return n;
  endfunction

  // A clear keeps the events of its own cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst)                               store_cnt_q <= 16'h0000;
    else if (wr_acc && paddr == `CTV_SCNT_OFS) store_cnt_q <= ones(stores);
    else                                       store_cnt_q <= store_cnt_q + ones(stores);
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst)                               reject_cnt_q <= 16'h0000;
    else if (wr_acc && paddr == `CTV_RCNT_OFS) reject_cnt_q <= ones(rejects);
    else                                       reject_cnt_q <= reject_cnt_q + ones(rejects);
  end
  // Read data and error are captured in the setup cycle, shown in the access cycle
  logic [31:0] rd_d;
  logic        err_d;
  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    unique case (paddr)
      `CTV_CTRL_OFS:  rd_d[4:0] = {paired_q, mode_q, master_q, run_q};
      `CTV_WIN_OFS:   rd_d[15:0] = win_len_q;
      `CTV_GEN_OFS:   rd_d[GW-1:0] = glb_en_q;
      `CTV_GFN_OFS:   rd_d[12:0] = {glb_lvl_q, 6'h00, glb_fn_q};
      `CTV_TEN_OFS:   rd_d[GW-1:0] = tout_en_q;
      `CTV_SOFT_OFS:  rd_d = 32'h0000_0000;
      `CTV_PHASE_OFS: rd_d[7:0] = phase_q;
      `CTV_STAT_OFS:  rd_d[NCH+1:0] = {chan_busy, busy_any, run_eff};
      `CTV_TIME_OFS:  rd_d = time_q;
      `CTV_SCNT_OFS:  rd_d[15:0] = store_cnt_q;
      `CTV_RCNT_OFS:  rd_d[15:0] = reject_cnt_q;
      default: begin
        err_d = 1'b1;
        for (int k = 0; k < NCH; k++) begin
          if (paddr == `CTV_CH_BASE + 8'(k) * `CTV_CH_STRIDE) begin
            rd_d[CW-1:0] = ch_en_q[k];
            err_d        = 1'b0;
          end else if (paddr == `CTV_CH_BASE + 8'(k) * `CTV_CH_STRIDE + `CTV_CH_FN_OFS) begin
            rd_d[12:0] = {ch_lvl_q[k], 6'h00, ch_fn_q[k]};
            err_d      = 1'b0;
          end
        end
      end
    endcase
  end

  logic err_q;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      err_q  <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
      err_q  <= err_d;
    end
  end
  assign pslverr = psel & penable & err_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_tout_or_only: assert property (
    board_trigger_output == $past(|(brd_in & tout_en_q)))
    else $error("board trigger output is not the OR of enabled inputs");
  a_normal_val_high: assert property (
    $past(mode_q) == MODE_NORMAL && $past(sys_rst) == 1'b0 |-> &trigger_validation)
    else $error("validation not held high in normal mode");
  a_glb_all_chan: assert property (
    mode_q inside {MODE_COINC, MODE_ANTI} && global_coincidence_output && $stable(mode_q) |=> &trigger_validation)
    else $error("global trigger did not validate every channel");
  a_neigh_spread: assert property (
    mode_q == MODE_NEIGH && req_src[1] |=> trigger_validation[0] && trigger_validation[2])
    else $error("neighbour request did not validate adjacent channels");
  a_busy_inhibit: assert property (
    inhibit |=> chan_event_store == '0)
    else $error("event stored while busy or stopped");
  a_time_stopped: assert property (
    !run_eff ##1 !run_eff |-> time_q == 32'h0000_0000)
    else $error("time base runs while acquisition stopped");
endmodule
`default_nettype wire

/* File: sim/ctv_front_model.sv */
// Front-end model: registers trigger requests and busy levels toward the block
`timescale 1ns/1ps
`default_nettype none
module ctv_front_model #(
  parameter int NCH = 8
) (
  input  wire logic           sys_clk,
  input  wire logic [NCH-1:0] fire,
  input  wire logic [NCH-1:0] hold_busy,
  output logic      [NCH-1:0] chan_trig_request,
  output logic      [NCH-1:0] chan_busy
);
  // Each request follows its fire bit one cycle later, as wide as the fire pulse, on the shared clock
  always_ff @(posedge sys_clk) begin
    chan_trig_request <= fire;
    chan_busy         <= hold_busy;
  end
endmodule
`default_nettype wire

/* File: sim/coincidence_trigger_validation_test.sv */
// Self-checking bench of the trigger validation top level
`timescale 1ns/1ps
`default_nettype none
module coincidence_trigger_validation_test;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
  localparam int NCH = 8;
  logic              sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]        paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, err, st, rj, bto, sa, sto, sbo, sro, cms;
  logic [NCH-1:0]    frq = '0, bsy = '0, req, busy, tval, stor, rejt, b15;
  logic [NCH-1:0]    m, en, sta, pil;
  logic [7:0]        gp = '0, cps;
  logic [NCH-1:0][31:0] etime;
  int                n_mismatch = 0, checked = 0, cyc = 0;
  ctv_front_model #(.NCH(NCH)) fe_u (.sys_clk(sys_clk), .fire(frq), .hold_busy(bsy),
    .chan_trig_request(req), .chan_busy(busy));
  ctv_top #(.NCH(NCH)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_trig_request(req), .chan_busy(busy),
    .gp_line(gp), .external_trigger_input(1'b0), .sync_run_in(1'b0),
    .sync_busy_in(1'b0), .sync_trig_in(1'b0), .trigger_validation(tval),
    .chan_event_start(sta), .chan_event_store(stor), .chan_event_reject(rejt),
    .chan_pileup_flag(pil), .chan_energy_bit15(b15), .chan_event_time(etime),
    .board_trigger_output(bto), .sync_run_out(sro), .sync_busy_out(sbo), .sync_trig_out(sto),
    .clk_master_sel(cms), .clk_phase_shift(cps));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    $display("Counts: checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task automatic apb(input int w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w[0]; paddr <= a; pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  // Fire a request mask, then wait for channel c to store or reject
  task automatic shot(input logic [NCH-1:0] fm, input int c);
    frq <= fm;
    @(posedge sys_clk) frq <= '0;
    st = 0;
    rj = 0;
    sa = 0;
    for (int i = 0; i < 40 && !(st | rj); i++) begin
      @(posedge sys_clk);
      st = stor[c];
      rj = rejt[c];
      sa = sa | sta[c];
    end
    repeat (4) @(posedge sys_clk);
  endtask
  function automatic logic expv(input int f, input logic [1:0] v);
    return (f == 1) ? |v : &v;
  endfunction
  initial begin
    void'($urandom(28));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 0;
    repeat (3) @(posedge sys_clk);
    `CHK(tval, {NCH{1'b1}})
    apb(0, 8'h04, 0);
    `CHK(rd, 32'h0000_0010)
    apb(0, 8'h3C, 0);
    `CHK(err, 1'b1)
    apb(1, 8'h18, 32'h5A);
    @(posedge sys_clk);
    `CHK(cps, 8'h5A)
    `CHK(cms, 1'b0)
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      en = NCH'($urandom);
      m = NCH'($urandom);
      apb(1, 8'h10, {24'h0, en});
      frq <= m;
      @(posedge sys_clk) frq <= '0;
      repeat (2) @(posedge sys_clk);
      `CHK(bto, |(m & en))
      `CHK(sto, |(m & en))
    end
    $display("trigger output test done");
    apb(1, 8'h08, 32'h100);
    apb(1, 8'h04, 2);
    apb(1, 8'h40, 32'h6);
    apb(1, 8'h00, 32'h7);
    apb(1, 8'h14, 0);
    @(posedge sys_clk);
    `CHK(tval, {NCH{1'b1}})
    `CHK(cms, 1'b1)
    `CHK(cps, 8'h00)
    `CHK(sro, 1'b1)
    apb(1, 8'h08, 0);
    for (int i = 0; i < 6; i++) begin
      m = NCH'($urandom);
      apb(1, 8'h44, (i % 3) | 32'h200);
      shot({m[2:1], 1'b1}, 0);
      `CHK(st, expv(i % 3, m[2:1]))
      `CHK(rj, !expv(i % 3, m[2:1]))
    end
    apb(1, 8'h40, 32'h100);
    apb(1, 8'h44, 1);
    gp <= 8'h01;
    shot(8'h01, 0);
    `CHK(st, 1'b1)
    gp <= 8'h00;
    bsy <= 8'h01;
    shot(8'h01, 0);
    `CHK(st | rj | sa, 1'b0)
    `CHK(sbo, 1'b1)
    bsy <= 8'h00;
    apb(1, 8'h40, 32'h6);
    $display("coincidence test done");
    apb(1, 8'h44, 1);
    apb(1, 8'h00, 32'hB);
    shot(8'h01, 0);
    `CHK(st, 1'b1)
    shot(8'h03, 0);
    `CHK(rj, 1'b1)
    $display("anti-coincidence test done");
    apb(1, 8'h00, 32'hF);
    shot(8'h08, 2);
    `CHK(st, 1'b1)
    `CHK(b15[2], 1'b1)
    `CHK(sa, 1'b1)
    `CHK(pil[2], 1'b0)
    `CHK(etime[2], etime[3])
    shot(8'h02, 0);
    `CHK(st, 1'b1)
    `CHK(b15[0], 1'b1)
    $display("neighbour test done");
    give_verdict;
  end
endmodule
`default_nettype wire
